// ---- rtl/tmcd_consts.vh ----
// Constants of the test mode command decoder
`ifndef TMCD_CONSTS_VH
`define TMCD_CONSTS_VH

// ************************************************************
// Message header
// ************************************************************
`define TMCD_PD_TEST 4'hF
`define TMCD_SKIP_NONE 4'h0
`define TMCD_SPACE_2G_A 4'h0
`define TMCD_SPACE_2G_B 4'h1
`define TMCD_SPACE_2G_C 4'h2
`define TMCD_SPACE_3G 4'h4

// ************************************************************
// Message types
// ************************************************************
`define TMCD_MT_CLOSE_LOOP 8'h00
`define TMCD_MT_CLOSE_ACK 8'h01
`define TMCD_MT_OPEN_LOOP 8'h06
`define TMCD_MT_ACT_MAINT 8'h0C
`define TMCD_MT_ACT_REPLY 8'h0D
`define TMCD_MT_DEACT_MAINT 8'h10
`define TMCD_MT_AUDIO_TEST 8'h14
`define TMCD_MT_CLOSE_MULTI 8'h20
`define TMCD_MT_NONE 8'h00

// ************************************************************
// Fields
// ************************************************************
`define TMCD_ACK_IEI 4'h8
`define TMCD_ACK_BODY 4'h1
`define TMCD_BODY_NONE 8'h00
`define TMCD_DROP_MAX 2'h3
`define TMCD_CODING_G 2'h0
`define TMCD_CODING_H 2'h1
`define TMCD_MECH_1 3'h0
`define TMCD_MECH_2 3'h1
`define TMCD_AUDIO_NORMAL 3'h0
`define TMCD_AUDIO_DECODER 3'h1
`define TMCD_AUDIO_ENCODER 3'h2
`define TMCD_AUDIO_ACOUSTIC 3'h4

// Loop codes: A..F, I
`define TMCD_LOOP_A 3'h0
`define TMCD_LOOP_B 3'h1
`define TMCD_LOOP_C 3'h2
`define TMCD_LOOP_D 3'h3
`define TMCD_LOOP_E 3'h4
`define TMCD_LOOP_F 3'h5
`define TMCD_LOOP_I 3'h6
`define TMCD_LOOP_BAD 3'h7

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define TMCD_REG_MSG 12'h000
`define TMCD_REG_STATUS 12'h004
`define TMCD_REG_REPLY 12'h008
`define TMCD_REG_CTRL 12'h00C
`define TMCD_ADDR_W 12

`endif

// ---- rtl/tmcd_decoder.v ----
// Test mode command decoder with AHB-Lite register access
//
// Behaviour
// - Nonzero skip indicator: discard message
// - Discriminator must be binary 1111
// - Upper nibbles 0000/0001/0010 are handset commands
// - Upper nibble 0100 never decoded here
// - Decode close, open, multi-slot types
// - Sub-channel bit 1 selects half-rate sub-channel
// - Sub-channel bits 6..2 select test loop
// - Close loop returns acknowledgement message
// - Open loop may carry acknowledge element
// - Loop-type bits 2..1 select coding
// - Loop-type bits 5..3 select mechanism
// - Slot number used only for mechanism 1
// - Maintenance activation needs test card present
// - Exactly one flow-on when interface ready
// - Deactivate on power-off, removal, command
// - No flow-off after deactivation
// - Activation command answered with activate reply
// - Deactivation command gets no reply
// - New audio function replaces previous one
// - Decode tested-device field bits 3..1
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "tmcd_consts.vh"

module tmcd_decoder (
  input wire clk_sys,
  input wire rst_n,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hsel,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire power_on,
  input wire subscriber_card_test,
  input wire audio_test_select_valid,
  input wire [2:0] audio_test_select,
  input wire maint_ready,
  output reg maintenance_interface_active,
  output reg flow_on_message,
  output reg loop_closed,
  output reg [2:0] loop_kind,
  output reg half_rate_sub,
  output reg multi_loop_closed,
  output reg [1:0] coding_select,
  output reg [2:0] loop_mechanism,
  output reg [2:0] slot_number,
  output reg [2:0] audio_test_interface,
  output reg reply_valid,
  output reg [15:0] reply_word
);

  // ************************************************************
  // Decode functions
  // ************************************************************
  function [2:0] loop_code;
    input [4:0] cy;
    begin
      casez (cy)
        5'b00000: loop_code = `TMCD_LOOP_A;
        5'b00001: loop_code = `TMCD_LOOP_B;
        5'b0001?: loop_code = `TMCD_LOOP_C;
        5'b001??: loop_code = `TMCD_LOOP_D;
        5'b010??: loop_code = `TMCD_LOOP_E;
        5'b011??: loop_code = `TMCD_LOOP_F;
        5'b111??: loop_code = `TMCD_LOOP_I;
        default: loop_code = `TMCD_LOOP_BAD;
      endcase
    end
  endfunction

  function audio_ok;
    input [2:0] td;
    begin
      case (td)
        `TMCD_AUDIO_NORMAL, `TMCD_AUDIO_DECODER, `TMCD_AUDIO_ENCODER, `TMCD_AUDIO_ACOUSTIC: audio_ok = 1'b1;
        default: audio_ok = 1'b0;
      endcase
    end
  endfunction

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  reg ph_valid_q;
  reg ph_write_q;
  reg [`TMCD_ADDR_W-1:0] ph_addr_q;
  reg [31:0] msg_q;
  reg msg_stb_q;
  reg [1:0] drop_cnt_q;
  reg [7:0] last_type_q;
  reg [7:0] ignored_cnt_q;
  wire addr_take;
  wire wr_msg;
  wire wr_ctrl;
  wire [`TMCD_ADDR_W-1:0] rd_addr;
  wire [31:0] status_word;
  wire [31:0] reply_reg;

  assign addr_take = hsel & hready & htrans[1];
  assign wr_msg = ph_valid_q & ph_write_q & (ph_addr_q == `TMCD_REG_MSG);
  assign wr_ctrl = ph_valid_q & ph_write_q & (ph_addr_q == `TMCD_REG_CTRL);
  assign rd_addr = haddr[`TMCD_ADDR_W-1:0];
  // Live state above the two event counters
  assign status_word = {2'h0, audio_test_interface, slot_number, loop_mechanism, coding_select,
    multi_loop_closed, half_rate_sub, loop_kind, loop_closed, maintenance_interface_active,
    ignored_cnt_q, 2'h0, drop_cnt_q};
  assign reply_reg = {15'h0000, reply_valid, reply_word};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      msg_q <= 32'h00000000;
      msg_stb_q <= 1'b0;
    end else begin
      ph_valid_q <= addr_take;
      ph_write_q <= hwrite;
      ph_addr_q <= rd_addr;
      msg_stb_q <= wr_msg;
      if (wr_msg) begin
        msg_q <= hwdata;
      end
      // Reads answer in the data phase straight from flops
      if (addr_take & ~hwrite) begin
        case (rd_addr)
          `TMCD_REG_MSG: hrdata <= msg_q;
          `TMCD_REG_STATUS: hrdata <= status_word;
          `TMCD_REG_REPLY: hrdata <= reply_reg;
          `TMCD_REG_CTRL: hrdata <= {24'h000000, last_type_q};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ************************************************************
  // Message fields: byte0 = skip|disc, byte1 = type, byte2 = body
  // ************************************************************
  wire [3:0] f_disc = msg_q[3:0];
  wire [3:0] f_skip = msg_q[7:4];
  wire [7:0] f_type = msg_q[15:8];
  wire [7:0] f_body = msg_q[23:16];
  wire [3:0] f_space = f_type[7:4];
  wire hdr_ok = (f_skip == `TMCD_SKIP_NONE) &
    (f_disc == `TMCD_PD_TEST);
  // Handset command space; 0100 space rejected
  wire space_ok = (f_space == `TMCD_SPACE_2G_A) | (f_space == `TMCD_SPACE_2G_B) |
    (f_space == `TMCD_SPACE_2G_C);
  wire accept = msg_stb_q & hdr_ok & space_ok & (f_space != `TMCD_SPACE_3G);
  wire [2:0] lk = loop_code(f_body[5:1]);
  // Spare bits 8..7 must be zero; bad codes ignored
  wire close_ok = (lk != `TMCD_LOOP_BAD) & (f_body[7:6] == 2'h0);
  wire coding_ok = (f_body[1:0] == `TMCD_CODING_G) | (f_body[1:0] == `TMCD_CODING_H);
  wire mech_ok = (f_body[4:2] == `TMCD_MECH_1) | (f_body[4:2] == `TMCD_MECH_2);
  wire open_ack = (f_body[7:4] == `TMCD_ACK_IEI) & (f_body[3:0] == `TMCD_ACK_BODY);

  // ************************************************************
  // Derived controls
  // ************************************************************
  reg card_q;
  reg power_q;
  reg flow_sent_q;
  wire power_rise;
  wire card_rise;
  wire maint_lost;
  wire act_cmd;
  wire deact_cmd;
  wire open_ok;
  wire [15:0] close_reply;
  wire [15:0] act_reply;

  // Power-on and card insertion seen as edges
  assign power_rise = power_on & ~power_q;
  assign card_rise = subscriber_card_test & ~card_q;
  // Loss of power or card is a level, not an edge
  assign maint_lost = ~power_on | ~subscriber_card_test;
  // Card must already be sampled present
  assign act_cmd = accept & (f_type == `TMCD_MT_ACT_MAINT) & card_q;
  assign deact_cmd = accept & (f_type == `TMCD_MT_DEACT_MAINT);
  // Body absent (all zero) or a well-formed element
  assign open_ok = (f_body == `TMCD_BODY_NONE) | open_ack;
  // Replies hold only header and type
  assign close_reply = {`TMCD_MT_CLOSE_ACK, `TMCD_SKIP_NONE, `TMCD_PD_TEST};
  assign act_reply = {`TMCD_MT_ACT_REPLY, `TMCD_SKIP_NONE, `TMCD_PD_TEST};

  // ************************************************************
  // Header statistics
  // ************************************************************
  // Saturating, so a flood of junk cannot wrap back to zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drop_cnt_q <= 2'h0;
      last_type_q <= `TMCD_MT_NONE;
    end else begin
      if (msg_stb_q & ~accept & (drop_cnt_q != `TMCD_DROP_MAX)) begin
        drop_cnt_q <= drop_cnt_q + 2'h1;
      end
      if (accept) begin
        last_type_q <= f_type;
      end
    end
  end

  // ************************************************************
  // Maintenance interface
  // ************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      maintenance_interface_active <= 1'b0;
      flow_on_message <= 1'b0;
      flow_sent_q <= 1'b0;
      card_q <= 1'b0;
      power_q <= 1'b0;
    end else begin
      card_q <= subscriber_card_test;
      power_q <= power_on;
      flow_on_message <= 1'b0;
      // Command, power-on or insertion, only with card and power
      if (act_cmd | (power_on & subscriber_card_test & (power_rise | card_rise))) begin
        maintenance_interface_active <= 1'b1;
      end
      // Any deactivation cause wins over activation
      if (deact_cmd | maint_lost) begin
        maintenance_interface_active <= 1'b0;
        flow_sent_q <= 1'b0;
      end
      // One flow-on per activation; no flow-off exists
      // A deactivation in this cycle blocks it, else the next activation stays silent
      if (maintenance_interface_active & maint_ready & ~flow_sent_q & ~deact_cmd & ~maint_lost) begin
        flow_on_message <= 1'b1;
        flow_sent_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Command execution
  // ************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loop_closed <= 1'b0;
      loop_kind <= `TMCD_LOOP_A;
      half_rate_sub <= 1'b0;
      multi_loop_closed <= 1'b0;
      coding_select <= `TMCD_CODING_G;
      loop_mechanism <= `TMCD_MECH_1;
      slot_number <= 3'h0;
      audio_test_interface <= `TMCD_AUDIO_NORMAL;
      reply_valid <= 1'b0;
      reply_word <= 16'h0000;
      ignored_cnt_q <= 8'h00;
    end else begin
      // Reply latch cleared by CTRL write; a new reply wins
      if (wr_ctrl & hwdata[0]) begin
        reply_valid <= 1'b0;
      end
      if (audio_test_select_valid & audio_ok(audio_test_select)) begin
        audio_test_interface <= audio_test_select;
      end
      if (accept) begin
        case (f_type)
          `TMCD_MT_CLOSE_LOOP: begin
            if (close_ok) begin
              loop_closed <= 1'b1;
              loop_kind <= lk;
              half_rate_sub <= f_body[0];
              reply_valid <= 1'b1;
              reply_word <= close_reply;
            end else begin
              ignored_cnt_q <= ignored_cnt_q + 8'h01;
            end
          end
          `TMCD_MT_OPEN_LOOP: begin
            // Malformed element drops the whole command
            if (open_ok) begin
              loop_closed <= 1'b0;
              multi_loop_closed <= 1'b0;
            end else begin
              ignored_cnt_q <= ignored_cnt_q + 8'h01;
            end
          end
          `TMCD_MT_CLOSE_MULTI: begin
            if (coding_ok & mech_ok) begin
              multi_loop_closed <= 1'b1;
              coding_select <= f_body[1:0];
              loop_mechanism <= f_body[4:2];
              // Slot number only for mechanism 1
              if (f_body[4:2] == `TMCD_MECH_1) begin
                slot_number <= f_body[7:5];
              end
            end else begin
              ignored_cnt_q <= ignored_cnt_q + 8'h01;
            end
          end
          `TMCD_MT_ACT_MAINT: begin
            // Reply only when activation really happens
            if (act_cmd & ~maint_lost) begin
              reply_valid <= 1'b1;
              reply_word <= act_reply;
            end
          end
          // No reply; the interface drops in its own block
          `TMCD_MT_DEACT_MAINT: begin
          end
          `TMCD_MT_AUDIO_TEST: begin
            if (audio_ok(f_body[2:0]) & (f_body[7:3] == 5'h00)) begin
              audio_test_interface <= f_body[2:0];
            end else begin
              ignored_cnt_q <= ignored_cnt_q + 8'h01;
            end
          end
          default: begin
            ignored_cnt_q <= ignored_cnt_q + 8'h01;
          end
        endcase
      end
    end
  end

endmodule // tmcd_decoder

// ---- sim/tb.sv ----
// Testbench of the test mode command decoder
`timescale 1ns/1ns
// ****
// Bench
// ****
module tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hsel = 1'b0, power_on = 1'b0;
  logic subscriber_card_test = 1'b0, audio_test_select_valid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, coding_select;
  logic [2:0] hsize = 3'h2, audio_test_select = 3'h0, loop_kind, slot_number, loop_mechanism, audio_test_interface;
  logic hreadyout, hresp, maint_ready, maintenance_interface_active, flow_on_message, loop_closed;
  logic half_rate_sub, multi_loop_closed, reply_valid;
  logic [15:0] reply_word;
  logic [7:0] flow_count;
  logic [7:0] sub_oct [0:6] = '{8'h00, 8'h03, 8'h06, 8'h0B, 8'h12, 8'h1D, 8'h3E};
  logic [15:0] rej [0:3] = '{16'h1F00, 16'h0E00, 16'h0F40, 16'h0F30};
  logic [2:0] dev [0:3] = '{3'h1, 3'h2, 3'h4, 3'h0};
  integer err_total = 0, samples_checked = 0, i;

  always #4 clk_sys = ~clk_sys;

  tmcd_decoder i_tmcd_decoder (.clk_sys, .rst_n, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .power_on, .subscriber_card_test,
    .audio_test_select_valid, .audio_test_select, .maint_ready, .maintenance_interface_active,
    .flow_on_message, .loop_closed, .loop_kind, .half_rate_sub, .multi_loop_closed, .coding_select,
    .loop_mechanism, .slot_number, .audio_test_interface, .reply_valid, .reply_word);
  tmcd_maint_peer i_tmcd_maint_peer (.clk_sys, .rst_n, .maintenance_interface_active,
    .flow_on_message, .maint_ready, .flow_count);

  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Single word transfer, held until hready
  task bus(input w, input [31:0] a, input [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  // Header byte is skip and discriminator
  task send(input [7:0] hd, input [7:0] t, input [7:0] o);
    bus(1'b1, 32'h0, {8'h00, o, t, hd});
    repeat (3) @(posedge clk_sys);
  endtask

  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #40000;
    err_total++;
    final_report;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    power_on <= 1'b1;
    send(8'h0F, 8'h0C, 8'h00);
    chk(maintenance_interface_active, 1'b0);
    subscriber_card_test <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk({maintenance_interface_active, flow_count}, 9'h101);
    subscriber_card_test <= 1'b0;
    repeat (12) @(posedge clk_sys);
    chk({maintenance_interface_active, flow_count}, 9'h001);
    subscriber_card_test <= 1'b1;
    repeat (12) @(posedge clk_sys);
    bus(1'b1, 32'hC, 32'h1);
    send(8'h0F, 8'h10, 8'h00);
    chk({maintenance_interface_active, reply_valid}, 2'h0);
    send(8'h0F, 8'h0C, 8'h00);
    chk({reply_valid, reply_word}, 17'h10D0F);
    repeat (12) @(posedge clk_sys);
    chk({maintenance_interface_active, flow_count}, 9'h103);
    for (i = 0; i < 7; i++) begin
      bus(1'b1, 32'hC, 32'h1);
      send(8'h0F, 8'h00, sub_oct[i]);
      chk({loop_closed, half_rate_sub, loop_kind}, {1'b1, sub_oct[i][0], i[2:0]});
      chk({reply_valid, reply_word}, 17'h1010F);
    end
    bus(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0001010F);
    send(8'h0F, 8'h00, 8'h20);
    chk(loop_kind, 3'h6);
    for (i = 0; i < 4; i++) begin
      send(rej[i][15:8], rej[i][7:0], 8'h03);
      chk({loop_closed, loop_kind}, 4'hE);
    end
    bus(1'b0, 32'h4, 32'h0);
    chk(rd[1:0], 2'h3);
    bus(1'b1, 32'h10, 32'h0000060F);
    chk({loop_closed, loop_kind}, 4'hE);
    send(8'h0F, 8'h06, 8'h8F);
    chk({loop_closed, loop_kind}, 4'hE);
    send(8'h0F, 8'h06, 8'h81);
    chk({loop_closed, multi_loop_closed}, 2'h0);
    send(8'h0F, 8'h20, 8'hA1);
    chk({multi_loop_closed, coding_select, loop_mechanism, slot_number}, 9'h145);
    send(8'h0F, 8'h20, 8'h64);
    chk({multi_loop_closed, coding_select, loop_mechanism, slot_number}, 9'h10D);
    send(8'h0F, 8'h20, 8'h02);
    chk({multi_loop_closed, coding_select, loop_mechanism}, 6'h21);
    send(8'h0F, 8'h20, 8'h08);
    chk({multi_loop_closed, coding_select, loop_mechanism}, 6'h21);
    // a loop stands as the dedicated channel before audio test messages
    for (i = 0; i < 4; i++) begin
      send(8'h0F, 8'h14, {5'h0, dev[i]});
      chk(audio_test_interface, dev[i]);
    end
    send(8'h0F, 8'h14, 8'h03);
    chk(audio_test_interface, 3'h0);
    audio_test_select <= 3'h4;
    audio_test_select_valid <= 1'b1;
    @(posedge clk_sys);
    audio_test_select_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(audio_test_interface, 3'h4);
    send(8'h0F, 8'h06, 8'h00);
    chk({loop_closed, multi_loop_closed}, 2'h0);
    power_on <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(maintenance_interface_active, 1'b0);
    final_report;
  end
endmodule // tb

// ---- sim/tmcd_checker.sv ----
// Port assertions for the test mode command decoder
`timescale 1ns/1ns
// ****
// Checker
// ****
module tmcd_checker (
  input wire clk_sys,
  input wire rst_n,
  input wire power_on,
  input wire subscriber_card_test,
  input wire maint_ready,
  input wire maintenance_interface_active,
  input wire flow_on_message,
  input wire loop_closed,
  input wire [2:0] loop_kind,
  input wire multi_loop_closed,
  input wire [1:0] coding_select,
  input wire [2:0] loop_mechanism,
  input wire [2:0] audio_test_interface,
  input wire reply_valid,
  input wire [15:0] reply_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_card_needed: assert property (
    $rose(maintenance_interface_active) |-> $past(subscriber_card_test) && $past(power_on))
    else $error("activation without card or power");
  chk_removal_drops: assert property (
    !subscriber_card_test || !power_on |=> !maintenance_interface_active)
    else $error("interface still active after removal");
  chk_flow_pulse: assert property (
    flow_on_message |=> !flow_on_message)
    else $error("flow-on longer than one cycle");
  chk_flow_when_ready: assert property (
    flow_on_message |-> $past(maintenance_interface_active) && $past(maint_ready))
    else $error("flow-on while inactive or not ready");
  chk_reply_header: assert property (
    reply_valid |-> reply_word[7:0] == 8'h0F)
    else $error("reply header wrong");
  chk_reply_kind: assert property (
    reply_valid |-> reply_word[15:8] == 8'h01 || reply_word[15:8] == 8'h0D)
    else $error("reply type wrong");
  chk_loop_code: assert property (
    loop_closed |-> loop_kind != 3'h7)
    else $error("bad loop code");
  chk_multi_fields: assert property (
    multi_loop_closed |-> coding_select[1] == 1'b0 && loop_mechanism[2:1] == 2'h0)
    else $error("reserved multi-slot field applied");
  chk_audio_code: assert property (
    audio_test_interface inside {3'h0, 3'h1, 3'h2, 3'h4})
    else $error("reserved tested device code");
endmodule // tmcd_checker

bind tmcd_decoder tmcd_checker i_tmcd_checker (.clk_sys, .rst_n, .power_on, .subscriber_card_test,
  .maint_ready, .maintenance_interface_active, .flow_on_message, .loop_closed, .loop_kind,
  .multi_loop_closed, .coding_select, .loop_mechanism, .audio_test_interface, .reply_valid, .reply_word);

// ---- sim/tmcd_maint_peer.sv ----
// Maintenance interface peer model
`timescale 1ns/1ns
// ****
// Peer
// ****
module tmcd_maint_peer #(
  parameter [3:0] READY_DELAY = 4'h3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire maintenance_interface_active,
  input wire flow_on_message,
  output logic maint_ready,
  output logic [7:0] flow_count
);
  logic [3:0] wait_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      maint_ready <= 1'b0;
      flow_count <= 8'h00;
    end else begin
      maint_ready <= maintenance_interface_active && wait_q == READY_DELAY;
      if (!maintenance_interface_active)
        wait_q <= 4'h0;
      else if (wait_q != READY_DELAY)
        wait_q <= wait_q + 4'h1;
      if (flow_on_message)
        flow_count <= flow_count + 8'h01;
    end
  end
endmodule // tmcd_maint_peer
